/* shared/rtc_alarm_map.vh */
// register offsets, field positions, reset values and timing counts of the alarm block
`ifndef RTC_ALARM_MAP_VH
`define RTC_ALARM_MAP_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_SEC          4'h0
`define OFS_MIN          4'h1
`define OFS_HOUR         4'h2
`define OFS_WDAY         4'h3
`define OFS_MDAY         4'h4
`define OFS_MONTH        4'h5
`define OFS_YEAR         4'h6
`define OFS_AL1_SEC      4'h7
`define OFS_AL1_MIN      4'h8
`define OFS_AL1_HOUR     4'h9
`define OFS_AL1_DAY      4'hA
`define OFS_AL2_MIN      4'hB
`define OFS_AL2_HOUR     4'hC
`define OFS_AL2_DAY      4'hD
`define OFS_CTRL         4'hE
`define OFS_STAT         4'hF

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define AL_MASK_BIT      7
`define AL_WEEKDAY_BIT   6
`define CTRL_OSC_DIS     7
`define CTRL_UNUSED      6
`define CTRL_GFIL        5
`define CTRL_RS_HI       4
`define CTRL_RS_LO       3
`define CTRL_STEER       2
`define CTRL_SECOND_ALARM_IRQ_EN        1
`define CTRL_FIRST_ALARM_IRQ_EN        0
`define STAT_OSF         7
`define STAT_STOP_DETECT_DISABLE        6
`define STAT_LOS         5
`define STAT_SEL_HI      4
`define STAT_SEL_LO      3
`define STAT_EXT_REF_ENABLE        2
`define STAT_A2F         1
`define STAT_A1F         0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CTRL_RST         8'h18
`define STAT_RST         8'hA0
`define ALARM_RST        8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_NS           40
`define GLITCH_NS        5000
`define GLITCH_CYC       ((`GLITCH_NS + `CLK_NS - 1) / `CLK_NS)
`define OSC_HZ           32768
`define JITTER_MS        2
`define JITTER_TICKS     ((`OSC_HZ * `JITTER_MS) / 1000)
`define REF_HZ_50        50
`define REF_HZ_60        60
`define REF_TOL_SHIFT    7

`endif

/* src/alarm_match.v */
// compare of one alarm's stored fields against the timekeeping values
`default_nettype none
`include "rtc_alarm_map.vh"

module alarm_match
(
   input  wire [7:0] al_sec,
   input  wire [7:0] al_min,
   input  wire [7:0] al_hour,
   input  wire [7:0] al_day,
   input  wire [7:0] tk_sec,
   input  wire [7:0] tk_min,
   input  wire [7:0] tk_hour,
   input  wire [7:0] tk_wday,
   input  wire [7:0] tk_mday,
   output wire       hit
);

   wire [5:0] day_ref;
   wire       sec_ok;
   wire       min_ok;
   wire       hour_ok;
   wire       day_ok;

   // a set mask bit turns its field into a don't-care
   assign sec_ok  = al_sec[`AL_MASK_BIT]  | (al_sec[6:0]  == tk_sec[6:0]);
   assign min_ok  = al_min[`AL_MASK_BIT]  | (al_min[6:0]  == tk_min[6:0]);
   assign hour_ok = al_hour[`AL_MASK_BIT] | (al_hour[6:0] == tk_hour[6:0]);
   assign day_ref = al_day[`AL_WEEKDAY_BIT] ? tk_wday[5:0] : tk_mday[5:0];
   assign day_ok  = al_day[`AL_MASK_BIT]  | (al_day[5:0]  == day_ref);
   assign hit     = sec_ok & min_ok & hour_ok & day_ok;

endmodule // alarm_match
`default_nettype wire

/* src/rtc_alarm_irq_control.v */
// alarm match, control/status registers, square wave and pin steering of the clock
`default_nettype none
`include "rtc_alarm_map.vh"

// Function
// - two alarms, registers 07h-0Ah and 0Bh-0Dh
// - bit 7 masks field; unmasked fields must match
// - day/date bit 6 selects weekday or monthday
// - first alarm mask combinations give listed rates
// - second alarm fires at second zero, listed rates
// - match sets flag regardless of interrupt enable
// - enabled set flag drives its steered pin; with steering 0 and reference on no alarm reaches a pin, second pin carries the square wave
// - control bit 7 disables oscillator, resets 0
// - control bit 5 enables 5us glitch filter
// - rate bits choose square wave, reset 11
// - rates divided from oscillator; 1Hz follows reference only when reference rate select is 1Hz
// - 1Hz correction jitter bounded to 2ms
// - steering 0: square wave on second pin
// - steering 1, no reference: alarm per pin
// - steering 1 with reference: both alarms second pin
// - steering and enables clear at reset
// - flags clear on written 0 only
// - interrupt pin low while routed flag set
// - reference rate select 1, 50, 60, 32768 Hz
module rtc_alarm_irq_control
(
   input  wire       core_clk,
   input  wire       rst_b,
   input  wire [3:0] reg_addr,
   input  wire       reg_wr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   input  wire       sec_update,
   input  wire [7:0] tk_sec,
   input  wire [7:0] tk_min,
   input  wire [7:0] tk_hour,
   input  wire [7:0] tk_wday,
   input  wire [7:0] tk_mday,
   input  wire [7:0] tk_month,
   input  wire [7:0] tk_year,
   input  wire       osc_in,
   output reg        osc_disable,
   output reg        glitch_filter_on,
   input  wire       first_pin_in,
   output reg        first_pin_out,
   output reg        first_pin_oe,
   output reg        second_pin_out,
   output reg        second_pin_oe
);

   // -------------------------------------------------------------------------
   // functions
   // -------------------------------------------------------------------------
   function [15:0] ref_expect;
      input [1:0]  sel;
      reg   [31:0] full;
      begin
         if (sel == 2'b00)
            full = `OSC_HZ;
         else if (sel == 2'b01)
            full = `OSC_HZ / `REF_HZ_50;
         else if (sel == 2'b10)
            full = `OSC_HZ / `REF_HZ_60;
         else
            full = 32'h00000001;
         ref_expect = full[15:0];
      end
   endfunction

   function [15:0] lim_step;
      input [15:0] err;
      reg   [31:0] cap;
      begin
         cap = `JITTER_TICKS;
         if (err > cap[15:0])
            lim_step = cap[15:0];
         else
            lim_step = err;
      end
   endfunction

   // -------------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------------
   reg  [7:0]  al1_sec_r;
   reg  [7:0]  al1_min_r;
   reg  [7:0]  al1_hour_r;
   reg  [7:0]  al1_day_r;
   reg  [7:0]  al2_min_r;
   reg  [7:0]  al2_hour_r;
   reg  [7:0]  al2_day_r;
   reg         sq_rate_sel_hi;
   reg         sq_rate_sel_lo;
   reg         irq_steering;
   reg         first_alarm_irq_en;
   reg         second_alarm_irq_en;
   reg         osc_stopped_flag;
   reg         stop_detect_disable;
   reg         ref_lost_flag;
   reg         ref_rate_sel_hi;
   reg         ref_rate_sel_lo;
   reg         ext_ref_enable;
   reg         first_alarm_flag;
   reg         second_alarm_flag;
   reg  [7:0]  rdata_nxt;
   wire        wr_ctrl;
   wire        wr_stat;
   wire        hit1;
   wire        hit2;
   wire        stop_evt;
   wire        lose_evt;

   assign wr_ctrl = reg_wr & (reg_addr == `OFS_CTRL);
   assign wr_stat = reg_wr & (reg_addr == `OFS_STAT);

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         al1_sec_r  <= `ALARM_RST;
         al1_min_r  <= `ALARM_RST;
         al1_hour_r <= `ALARM_RST;
         al1_day_r  <= `ALARM_RST;
         al2_min_r  <= `ALARM_RST;
         al2_hour_r <= `ALARM_RST;
         al2_day_r  <= `ALARM_RST;
      end
      else if (reg_wr)
      begin
         // alarm contents reset to zero, then are written by software
         if (reg_addr == `OFS_AL1_SEC)
            al1_sec_r <= reg_wdata;
         else if (reg_addr == `OFS_AL1_MIN)
            al1_min_r <= reg_wdata;
         else if (reg_addr == `OFS_AL1_HOUR)
            al1_hour_r <= reg_wdata;
         else if (reg_addr == `OFS_AL1_DAY)
            al1_day_r <= reg_wdata;
         else if (reg_addr == `OFS_AL2_MIN)
            al2_min_r <= reg_wdata;
         else if (reg_addr == `OFS_AL2_HOUR)
            al2_hour_r <= reg_wdata;
         else if (reg_addr == `OFS_AL2_DAY)
            al2_day_r <= reg_wdata;
      end
   end

   // control register; bit 6 has no storage
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         osc_disable         <= 1'b0;
         glitch_filter_on    <= 1'b0;
         sq_rate_sel_hi      <= 1'b1;
         sq_rate_sel_lo      <= 1'b1;
         irq_steering        <= 1'b0;
         second_alarm_irq_en <= 1'b0;
         first_alarm_irq_en  <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         osc_disable         <= reg_wdata[`CTRL_OSC_DIS];
         glitch_filter_on    <= reg_wdata[`CTRL_GFIL];
         sq_rate_sel_hi      <= reg_wdata[`CTRL_RS_HI];
         sq_rate_sel_lo      <= reg_wdata[`CTRL_RS_LO];
         irq_steering        <= reg_wdata[`CTRL_STEER];
         second_alarm_irq_en <= reg_wdata[`CTRL_SECOND_ALARM_IRQ_EN];
         first_alarm_irq_en  <= reg_wdata[`CTRL_FIRST_ALARM_IRQ_EN];
      end
   end

   // -------------------------------------------------------------------------
   // alarm compare
   // -------------------------------------------------------------------------
   alarm_match u_match1
   (
      .al_sec  (al1_sec_r),
      .al_min  (al1_min_r),
      .al_hour (al1_hour_r),
      .al_day  (al1_day_r),
      .tk_sec  (tk_sec),
      .tk_min  (tk_min),
      .tk_hour (tk_hour),
      .tk_wday (tk_wday),
      .tk_mday (tk_mday),
      .hit     (hit1)
   );

   // the second alarm has no seconds field: it is pinned to second zero
   alarm_match u_match2
   (
      .al_sec  (8'h00),
      .al_min  (al2_min_r),
      .al_hour (al2_hour_r),
      .al_day  (al2_day_r),
      .tk_sec  (tk_sec),
      .tk_min  (tk_min),
      .tk_hour (tk_hour),
      .tk_wday (tk_wday),
      .tk_mday (tk_mday),
      .hit     (hit2)
   );

   // -------------------------------------------------------------------------
   // status register
   // -------------------------------------------------------------------------
   reg osc_dis_d_r;

   assign stop_evt = osc_disable & ~osc_dis_d_r & ~stop_detect_disable;

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         osc_dis_d_r         <= 1'b0;
         osc_stopped_flag    <= 1'b1;
         stop_detect_disable <= 1'b0;
         ref_lost_flag       <= 1'b1;
         ref_rate_sel_hi     <= 1'b0;
         ref_rate_sel_lo     <= 1'b0;
         ext_ref_enable      <= 1'b0;
         first_alarm_flag    <= 1'b0;
         second_alarm_flag   <= 1'b0;
      end
      else
      begin
         osc_dis_d_r <= osc_disable;
         if (wr_stat)
         begin
            stop_detect_disable <= reg_wdata[`STAT_STOP_DETECT_DISABLE];
            ref_rate_sel_hi     <= reg_wdata[`STAT_SEL_HI];
            ref_rate_sel_lo     <= reg_wdata[`STAT_SEL_LO];
            ext_ref_enable      <= reg_wdata[`STAT_EXT_REF_ENABLE];
         end
         // a set arriving with a clearing write wins
         if (stop_evt)
            osc_stopped_flag <= 1'b1;
         else if (wr_stat & ~reg_wdata[`STAT_OSF])
            osc_stopped_flag <= 1'b0;
         if (lose_evt)
            ref_lost_flag <= 1'b1;
         else if (wr_stat & ~reg_wdata[`STAT_LOS])
            ref_lost_flag <= 1'b0;
         if (sec_update & hit1)
            first_alarm_flag <= 1'b1;
         else if (wr_stat & ~reg_wdata[`STAT_A1F])
            first_alarm_flag <= 1'b0;
         if (sec_update & hit2)
            second_alarm_flag <= 1'b1;
         else if (wr_stat & ~reg_wdata[`STAT_A2F])
            second_alarm_flag <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------------------
   always @*
   begin
      if (reg_addr == `OFS_SEC)
         rdata_nxt = tk_sec;
      else if (reg_addr == `OFS_MIN)
         rdata_nxt = tk_min;
      else if (reg_addr == `OFS_HOUR)
         rdata_nxt = tk_hour;
      else if (reg_addr == `OFS_WDAY)
         rdata_nxt = tk_wday;
      else if (reg_addr == `OFS_MDAY)
         rdata_nxt = tk_mday;
      else if (reg_addr == `OFS_MONTH)
         rdata_nxt = tk_month;
      else if (reg_addr == `OFS_YEAR)
         rdata_nxt = tk_year;
      else if (reg_addr == `OFS_AL1_SEC)
         rdata_nxt = al1_sec_r;
      else if (reg_addr == `OFS_AL1_MIN)
         rdata_nxt = al1_min_r;
      else if (reg_addr == `OFS_AL1_HOUR)
         rdata_nxt = al1_hour_r;
      else if (reg_addr == `OFS_AL1_DAY)
         rdata_nxt = al1_day_r;
      else if (reg_addr == `OFS_AL2_MIN)
         rdata_nxt = al2_min_r;
      else if (reg_addr == `OFS_AL2_HOUR)
         rdata_nxt = al2_hour_r;
      else if (reg_addr == `OFS_AL2_DAY)
         rdata_nxt = al2_day_r;
      else if (reg_addr == `OFS_CTRL)
         rdata_nxt = {osc_disable, 1'b0, glitch_filter_on,
                      sq_rate_sel_hi, sq_rate_sel_lo, irq_steering,
                      second_alarm_irq_en, first_alarm_irq_en};
      else
         rdata_nxt = {osc_stopped_flag, stop_detect_disable, ref_lost_flag,
                      ref_rate_sel_hi, ref_rate_sel_lo, ext_ref_enable,
                      second_alarm_flag, first_alarm_flag};
   end

   always @(posedge core_clk)
   begin
      if (!rst_b)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= rdata_nxt;
   end

   // -------------------------------------------------------------------------
   // oscillator input: synchroniser, glitch filter, edge
   // -------------------------------------------------------------------------
   reg        osc_s1_r;
   reg        osc_s2_r;
   reg        osc_f_r;
   reg  [7:0] gf_cnt_r;
   reg        osc_f_d_r;
   wire       osc_edge;

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         osc_s1_r  <= 1'b0;
         osc_s2_r  <= 1'b0;
         osc_f_r   <= 1'b0;
         osc_f_d_r <= 1'b0;
         gf_cnt_r  <= 8'h00;
      end
      else
      begin
         osc_s1_r  <= osc_in;
         osc_s2_r  <= osc_s1_r;
         osc_f_d_r <= osc_f_r;
         // a level must hold the filter time before it is accepted
         if (osc_s2_r == osc_f_r)
            gf_cnt_r <= 8'h00;
         else if (!glitch_filter_on || gf_cnt_r == `GLITCH_CYC - 1)
         begin
            osc_f_r  <= osc_s2_r;
            gf_cnt_r <= 8'h00;
         end
         else
            gf_cnt_r <= gf_cnt_r + 8'h01;
      end
   end

   // a disabled oscillator stops every divided rate
   assign osc_edge = osc_f_r & ~osc_f_d_r & ~osc_disable;

   // -------------------------------------------------------------------------
   // reference input: synchroniser and period check
   // -------------------------------------------------------------------------
   reg         ref_s1_r;
   reg         ref_s2_r;
   reg         ref_d_r;
   reg  [15:0] ref_per_r;
   reg         ref_ok_r;
   wire        ref_edge;
   wire [15:0] exp_cnt;
   wire [15:0] tol;
   wire        per_bad;

   assign ref_edge = ref_s2_r & ~ref_d_r & ext_ref_enable;
   assign exp_cnt  = ref_expect({ref_rate_sel_hi, ref_rate_sel_lo});
   assign tol      = (exp_cnt >> `REF_TOL_SHIFT) | 16'h0001;
   assign per_bad  = (ref_per_r < exp_cnt - tol) | (ref_per_r > exp_cnt + tol);
   assign lose_evt = ~ext_ref_enable | (ref_edge & per_bad) |
                     (ref_per_r > exp_cnt + tol);

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         ref_s1_r  <= 1'b0;
         ref_s2_r  <= 1'b0;
         ref_d_r   <= 1'b0;
         ref_per_r <= 16'h0000;
         ref_ok_r  <= 1'b0;
      end
      else
      begin
         ref_s1_r <= first_pin_in;
         ref_s2_r <= ref_s1_r;
         ref_d_r  <= ref_s2_r;
         if (!ext_ref_enable)
         begin
            ref_per_r <= 16'h0000;
            ref_ok_r  <= 1'b0;
         end
         else if (ref_edge)
         begin
            ref_per_r <= 16'h0000;
            ref_ok_r  <= ~per_bad;
         end
         else
         begin
            if (osc_edge && ref_per_r != 16'hFFFF)
               ref_per_r <= ref_per_r + 16'h0001;
            if (ref_per_r > exp_cnt + tol)
               ref_ok_r <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // square wave divider
   // -------------------------------------------------------------------------
   reg  [14:0] div_r;
   reg  [14:0] div_nxt;
   reg  [15:0] pull_step;
   reg         sq_r;
   wire        cond_on;

   assign cond_on = ref_ok_r & ~ref_rate_sel_hi & ~ref_rate_sel_lo;

   always @*
   begin
      div_nxt   = div_r;
      pull_step = lim_step(div_r[14] ? 16'h8000 - {1'b0, div_r} : {1'b0, div_r});
      if (cond_on && ref_edge)
      begin
         // pull the phase toward the reference a bounded step at a time
         if (!div_r[14])
            div_nxt = div_r - pull_step[14:0];
         else
            div_nxt = div_r + pull_step[14:0];
      end
      else if (osc_edge)
         div_nxt = div_r + 15'h0001;
   end

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         div_r <= 15'h0000;
         sq_r  <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         case ({sq_rate_sel_hi, sq_rate_sel_lo})
            2'b00:   sq_r <= div_r[14];
            2'b01:   sq_r <= div_r[2];
            2'b10:   sq_r <= div_r[1];
            default: sq_r <= osc_f_r & ~osc_disable;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // pin steering; open drain, driven only low
   // -------------------------------------------------------------------------
   wire a1_act;
   wire a2_act;

   assign a1_act = first_alarm_flag & first_alarm_irq_en;
   assign a2_act = second_alarm_flag & second_alarm_irq_en;

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         first_pin_out  <= 1'b0;
         first_pin_oe   <= 1'b0;
         second_pin_out <= 1'b0;
         second_pin_oe  <= 1'b0;
      end
      else
      begin
         first_pin_out  <= 1'b0;
         second_pin_out <= 1'b0;
         if (ext_ref_enable)
            first_pin_oe <= 1'b0;
         else if (irq_steering)
            first_pin_oe <= a1_act;
         else
            first_pin_oe <= a1_act | a2_act;
         if (!irq_steering)
            second_pin_oe <= ~sq_r;
         else if (ext_ref_enable)
            second_pin_oe <= a1_act | a2_act;
         else
            second_pin_oe <= a2_act;
      end
   end

endmodule // rtc_alarm_irq_control
`default_nettype wire

/* testbench/rtc_alarm_irq_control_asserts.sv */
// port-level assertions of the alarm and steering block
`default_nettype none
module rtc_alarm_irq_control_asserts
(
   input wire logic       core_clk,
   input wire logic       rst_b,
   input wire logic [3:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       sec_update,
   input wire logic       osc_disable,
   input wire logic       glitch_filter_on,
   input wire logic       first_pin_out,
   input wire logic       first_pin_oe,
   input wire logic       second_pin_out,
   input wire logic       second_pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   property p_follow(logic b, logic q);
      disable iff (!rst_b) reg_wr && reg_addr == 4'hE |=> q == $past(b);
   endproperty
   a_osc_dis_follow: assert property (p_follow(reg_wdata[7], osc_disable))
      else $error("osc_disable does not follow control bit 7");
   a_glitch_en_follow: assert property (p_follow(reg_wdata[5], glitch_filter_on))
      else $error("glitch_filter_on does not follow control bit 5");
   a_unused_bit_zero: assert property (disable iff (!rst_b)
      $past(reg_addr) == 4'hE |-> !reg_rdata[6]) else $error("control bit 6 reads one");
   a_first_low_only: assert property (disable iff (!rst_b) !first_pin_out)
      else $error("first pin driven high");
   a_second_low_only: assert property (disable iff (!rst_b) !second_pin_out)
      else $error("second pin driven high");
   a_pins_off_reset: assert property (!rst_b |=> !first_pin_oe && !second_pin_oe)
      else $error("pin driven after reset");
   a_first_rise_cause: assert property (disable iff (!rst_b)
      $rose(first_pin_oe) |-> $past(sec_update, 2) || $past(reg_wr, 2) || $past(reg_wr))
      else $error("first pin asserted without alarm or write");
   a_first_fall_cause: assert property (disable iff (!rst_b)
      $fell(first_pin_oe) |-> $past(reg_wr, 2) || $past(reg_wr))
      else $error("first pin released without a write");
   c_alarm_pin: cover property (sec_update ##2 first_pin_oe);
   c_second_pin: cover property ($rose(second_pin_oe));
   c_status_write: cover property (reg_wr && reg_addr == 4'hF);
endmodule // rtc_alarm_irq_control_asserts
bind rtc_alarm_irq_control rtc_alarm_irq_control_asserts i_rtc_alarm_irq_control_asserts
(
   .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sec_update(sec_update),
   .osc_disable(osc_disable), .glitch_filter_on(glitch_filter_on),
   .first_pin_out(first_pin_out), .first_pin_oe(first_pin_oe),
   .second_pin_out(second_pin_out), .second_pin_oe(second_pin_oe)
);
`default_nettype wire

/* testbench/pin_host.sv */
// host side of the two open-drain pins: pull-ups, reference drive, edge count
`default_nettype none
module pin_host
(
   input  wire logic       core_clk,
   input  wire logic       first_pin_out,
   input  wire logic       first_pin_oe,
   input  wire logic       second_pin_out,
   input  wire logic       second_pin_oe,
   input  wire logic       ref_drive,
   input  wire logic       ref_level,
   input  wire logic       cnt_clr,
   output var  logic       first_level,
   output var  logic       second_level,
   output var  logic [7:0] edge_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_r;
   // pull-up wins when nobody pulls low; host drives reference only in input mode
   assign first_level = first_pin_oe ? first_pin_out : (ref_drive ? ref_level : 1'b1);
   assign second_level = second_pin_oe ? second_pin_out : 1'b1;
   always @(posedge core_clk)
   begin
      last_r <= second_level;
      edge_cnt <= cnt_clr ? 8'h00 : edge_cnt + {7'h00, last_r !== second_level};
   end
endmodule // pin_host
`default_nettype wire

/* testbench/rtc_alarm_irq_control_tb.sv */
// self-checking bench of the alarm and steering block
`default_nettype none
module rtc_alarm_irq_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [1:0] kind; logic [7:0] exp;} note_t;
   logic       core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, sec_update = 1'b0;
   logic       osc_in = 1'b1, osc_run = 1'b0, ref_drive = 1'b0, cnt_clr = 1'b0, look = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] tk [7] = '{default: 8'h00};
   logic [7:0] reg_rdata, edge_cnt, rnd;
   logic       osc_disable, glitch_filter_on, first_pin_out, first_pin_oe;
   logic       second_pin_out, second_pin_oe, first_level, second_level;
   logic [3:0] m_tab [5] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'h0};
   logic [7:0] sq_tab [4] = '{8'h00, 8'h14, 8'h28, 8'hA0};
   int         n_errors = 0, samples_checked = 0;
   note_t      q [$];
   note_t      cur;
   always #20 core_clk = ~core_clk;
   always #160 if (osc_run) osc_in = ~osc_in;
   rtc_alarm_irq_control i_rtc_alarm_irq_control
   (
      .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sec_update(sec_update),
      .tk_sec(tk[0]), .tk_min(tk[1]), .tk_hour(tk[2]), .tk_wday(tk[3]), .tk_mday(tk[4]),
      .tk_month(tk[5]), .tk_year(tk[6]), .osc_in(osc_in), .osc_disable(osc_disable),
      .glitch_filter_on(glitch_filter_on), .first_pin_in(first_level),
      .first_pin_out(first_pin_out), .first_pin_oe(first_pin_oe),
      .second_pin_out(second_pin_out), .second_pin_oe(second_pin_oe)
   );
   pin_host i_pin_host
   (
      .core_clk(core_clk), .first_pin_out(first_pin_out), .first_pin_oe(first_pin_oe),
      .second_pin_out(second_pin_out), .second_pin_oe(second_pin_oe),
      .ref_drive(ref_drive), .ref_level(osc_in), .cnt_clr(cnt_clr),
      .first_level(first_level), .second_level(second_level), .edge_cnt(edge_cnt)
   );
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic note(input logic [1:0] k, input logic [7:0] e);
      q.push_back('{k, e});
      look = 1'b1;
      @(negedge core_clk);
      look = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      reg_addr = a;
      @(negedge core_clk);
      note(2'h0, e);
   endtask
   // one alarm programmed with masks m, the time off by one in field k
   task automatic probe(input int a, input logic [3:0] m, input int k, input logic wd);
      logic [7:0] f [4];
      logic [7:0] v [4];
      logic       hit;
      f = '{8'h00, 8'h34, 8'h05, 8'h06};
      hit = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         v[i] = f[i] ^ ((k == i) ? 8'h01 : 8'h00);
         if (k == i && !(m[i] && !(a == 2 && i == 0))) hit = 1'b0;
         if (a == 1 || i > 0) wr((a == 1 ? 4'h7 : 4'hA) + i[3:0], {m[i], wd & (i == 3), f[i][5:0]});
      end
      wr(a == 1 ? 4'hB : 4'h7, 8'h59);
      wr(4'hF, 8'h00);
      tk[0] = v[0];
      tk[1] = v[1];
      tk[2] = v[2];
      tk[3] = wd ? v[3] : f[3];
      tk[4] = wd ? f[3] : v[3];
      tk[5] = 8'(($urandom % 12) + 1);
      tk[6] = 8'($urandom % 10);
      sec_update = 1'b1;
      @(negedge core_clk);
      sec_update = 1'b0;
      rd(4'hF, 8'h20 | (a == 1 ? {7'h00, hit} : {6'h00, hit, 1'b0}));
   endtask
   // ---------------------------------------------------------------------------
   // result watcher
   // ---------------------------------------------------------------------------
   always @(posedge core_clk)
   begin
      if (look === 1'b1)
      begin
         cur = q.pop_front();
         case (cur.kind)
            2'h0: check(reg_rdata, cur.exp);
            2'h1: check({6'h00, first_pin_oe, second_pin_oe}, cur.exp);
            default: check((edge_cnt - cur.exp + 8'h01 <= 8'h02) ? cur.exp : edge_cnt, cur.exp);
         endcase
      end
   end
   initial
   begin
      #(20000 * 40);
      n_errors++;
      print_verdict();
   end
   initial
   begin
      rnd = 8'($urandom(32'h0633C502));
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      rd(4'hE, 8'h18);
      rd(4'hF, 8'hA0);
      rnd = 8'($urandom);
      wr(4'hE, rnd);
      rd(4'hE, rnd & 8'hBF);
      wr(4'hE, 8'h04);
      for (int mi = 0; mi < 5; mi++)
         for (int k = 0; k < 4; k++)
         begin
            probe(1, m_tab[mi], k, 1'($urandom));
            if (mi > 0) probe(2, m_tab[mi], k, 1'($urandom));
         end
      probe(1, 4'hF, 0, 1'b0);
      for (int r = 0; r < 4; r++)
      begin
         ref_drive = r[0];
         wr(4'hF, {5'h00, r[0], 2'h3});
         wr(4'hE, {3'h0, 2'h3, r[1], 2'h3});
         repeat (3) @(negedge core_clk);
         note(2'h1, {6'h00, !r[0], r[1] & r[0]});
      end
      wr(4'hF, 8'h04);
      wr(4'hF, 8'h00);
      ref_drive = 1'b0;
      repeat (3) @(negedge core_clk);
      note(2'h1, 8'h00);
      osc_run = 1'b1;
      for (int r = 0; r < 4; r++)
      begin
         wr(4'hE, {3'h0, r[1:0], 3'h0});
         repeat (40) @(negedge core_clk);
         cnt_clr = 1'b1;
         @(negedge core_clk);
         cnt_clr = 1'b0;
         repeat (640) @(negedge core_clk);
         note(2'h2, sq_tab[r]);
      end
      @(negedge core_clk);
      print_verdict();
   end
endmodule // rtc_alarm_irq_control_tb
`default_nettype wire
